// *** dv/owi_mst.sv ***
// Purpose: Behavioural two-wire bus master for the wiper slave.
// Assumes: Bench resolves SDA with a pull-up.
// Notes: SCL stands high between frames; 48 ns bit period.
`timescale 1ns/100ps
`default_nettype none
module owi_mst (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  // Idle: both lines released
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  // Start or repeated start, SDA falls with SCL high
  task start;
    sda_pull = 1'b0;
    #12 scl = 1'b1;
    #12 sda_pull = 1'b1;
    #12 scl = 1'b0;
    #12;
  endtask : start
  // Set SDA while SCL low; sample at the falling edge
  task bit_io(input logic b, output logic r);
    sda_pull = ~b;
    #12 scl = 1'b1;
    #24 r = sda;
    scl = 1'b0;
    #12;
  endtask : bit_io
  // Eight bits MSB first, then the acknowledge slot
  task xfer(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
    output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(mack, ack);
  endtask : xfer
  // Stop: SDA rises with SCL high, then the clock stands still
  task stop;
    sda_pull = 1'b1;
    #12 scl = 1'b1;
    #12 sda_pull = 1'b0;
    #24;
  endtask : stop
endmodule : owi_mst
`default_nettype wire

// *** dv/owi_slave_props.sv ***
// Purpose: Port assertions for the wiper serial slave.
// Assumes: ref_clk domain; fuse inputs static around boot.
// Notes: Burn length counted in helper logic.
`timescale 1ns/100ps
`default_nettype none
module owi_slave_props #(
  parameter int PROG_CYCLES = 20
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic addr_select_pin,
  input wire logic [1:0] fuse_state,
  input wire logic [5:0] fuse_code,
  input wire logic [5:0] wiper_resistor,
  input wire logic fuse_blow,
  input wire logic fuse_check_hi,
  input wire logic fuse_check_lo
);
  int blow_cnt; // Cycles of the current burn
  wire logic [1:0] chk = {fuse_check_hi, fuse_check_lo}; // Validation pair
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // Burn counter; zero whenever idle
  always_ff @(posedge ref_clk)
  begin
    blow_cnt <= fuse_blow ? blow_cnt + 1 : 0;
  end
  // Reset just released
  sequence s_rel;
    $rose(resetn);
  endsequence
  // Burn just ended
  sequence s_end;
    $fell(fuse_blow);
  endsequence
  // Boot loads the pair, and the frozen code only when programmed
  property p_boot;
    s_rel |-> ##8 (chk == fuse_state && wiper_resistor ==
      (fuse_state == 2'h3 ? fuse_code : owi_pkg::OWI_MIDSCALE));
  endproperty
  AST_BOOT_LOAD: assert property (p_boot)
    else $error("boot load wrong");
  AST_REL_MID: assert property (s_rel |-> wiper_resistor == 6'h20 && !fuse_blow && !sda_oe)
    else $error("not midscale after reset");
  AST_SCL_HI_HOLD: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("SDA moved while SCL high");
  AST_OE_LOW: assert property (sda_oe |-> !sda_out)
    else $error("driven SDA not low");
  AST_BLOW_LEN: assert property (s_end |-> blow_cnt == PROG_CYCLES)
    else $error("burn length wrong");
  AST_BLOW_ONCE: assert property ($rose(fuse_blow) |-> $past(chk) != 2'h3)
    else $error("burn after programming");
  AST_BURN_HOLD: assert property (fuse_blow |-> $stable(wiper_resistor))
    else $error("wiper moved in burn");
  AST_CHK_NEW: assert property (s_end |-> ##[1:4] (chk == fuse_state))
    else $error("pair not refreshed");
  AST_LOCK: assert property (chk == 2'h3 |=> $stable(wiper_resistor))
    else $error("locked wiper moved");
endmodule : owi_slave_props
bind owi_slave owi_slave_props #(.PROG_CYCLES(PROG_CYCLES)) i_props (
  .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin(addr_select_pin),
  .fuse_state(fuse_state), .fuse_code(fuse_code), .wiper_resistor(wiper_resistor),
  .fuse_blow(fuse_blow), .fuse_check_hi(fuse_check_hi), .fuse_check_lo(fuse_check_lo));
`default_nettype wire

// *** dv/tb_owi_slave.sv ***
// Purpose: Self-checking bench for the wiper serial slave.
// Assumes: Master model on the link; bench models the fuses.
// Notes: Burn shortened to 20 cycles; SDA has a pull-up.
`timescale 1ns/100ps
`default_nettype none
module tb_owi_slave;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic sel = 1'b0; // Address-select level
  logic [1:0] fuse_state = 2'h0;
  logic [5:0] fuse_code = 6'h0;
  logic [5:0] exp_w = 6'h20; // Wiper model
  logic [7:0] d; // Data byte
  logic blown = 1'b0; // Burn seen
  logic mack_seen; // Acknowledge level seen by the master, unused
  int n_fail = 0;
  int check_count = 0;
  wire logic scl, pull, sda_out, sda_oe, fblow, chk_hi, chk_lo;
  wire logic [5:0] wiper;
  wire logic sda = ~(pull | (sda_oe & ~sda_out)); // Pull-up wins when released
  always #5 ref_clk = ~ref_clk;
  owi_mst i_mst (.scl(scl), .sda_pull(pull), .sda(sda));
  owi_slave #(.PROG_CYCLES(20)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_select_pin(sel), .fuse_state(fuse_state),
    .fuse_code(fuse_code), .wiper_resistor(wiper), .fuse_blow(fblow),
    .fuse_check_hi(chk_hi), .fuse_check_lo(chk_lo));
  // Fuse array: a burn freezes the code and reports success
  always @(negedge ref_clk)
  begin
    if (fblow)
    begin
      blown <= 1'b1;
      fuse_state <= 2'h3;
      fuse_code <= exp_w;
    end
  end
  // Compare and count
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Verdict, single exit
  task end_of_test;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // Read byte: pair then code
  function automatic logic [7:0] exp_rd(input logic [1:0] st, input logic [5:0] w);
    return {st, w};
  endfunction : exp_rd
  // Own address with direction bit
  function automatic logic [7:0] adr(input logic rw);
    return {owi_pkg::OWI_ADDR_HI, sel, rw};
  endfunction : adr
  // Reset with a fuse report, then wait out the boot
  task do_reset(input logic [1:0] st);
    @(negedge ref_clk);
    resetn <= 1'b0;
    fuse_state <= st;
    fuse_code <= 6'($urandom);
    sel <= 1'($urandom);
    repeat (5) @(negedge ref_clk);
    resetn <= 1'b1;
    repeat (10) @(negedge ref_clk);
  endtask : do_reset
  // One written byte and its acknowledge level
  task wb(input logic [7:0] b, input logic eack);
    logic [7:0] r;
    logic ack;
    i_mst.xfer(b, 1'b1, r, ack);
    check({7'h0, ack}, {7'h0, eack});
  endtask : wb
  // Whole read, master refuses the byte
  task rd(input logic [7:0] a, input logic eack, input logic [7:0] ed);
    logic [7:0] r;
    logic ack;
    i_mst.start();
    wb(a, eack);
    i_mst.xfer(8'hff, 1'b1, r, ack);
    check(r, ed);
    i_mst.stop();
  endtask : rd
  // Write header: address then instruction
  task whead(input logic [7:0] ins);
    i_mst.start();
    wb(adr(1'b0), 1'b0);
    wb(ins, 1'b0);
  endtask : whead
  initial
  begin
    void'($urandom(32'hfde9d1d3));
    for (int s = 0; s < 4; s++)
    begin
      do_reset(2'(s));
      exp_w = (s == 3) ? fuse_code : 6'h20;
      repeat (2) rd(adr(1'b1), 1'b0, exp_rd(2'(s), exp_w));
      check({6'h0, chk_hi, chk_lo}, {6'h0, 2'(s)});
    end
    $display("test boot_read done");
    do_reset(2'h0);
    exp_w = 6'h20;
    rd({owi_pkg::OWI_ADDR_HI ^ 6'h01, sel, 1'b1}, 1'b1, 8'hff);
    rd({owi_pkg::OWI_ADDR_HI, ~sel, 1'b1}, 1'b1, 8'hff);
    i_mst.start();
    wb({owi_pkg::OWI_ADDR_HI, ~sel, 1'b0}, 1'b1);
    wb(8'h00, 1'b1);
    wb(8'h05, 1'b1);
    i_mst.stop();
    check({2'h0, wiper}, {2'h0, exp_w});
    $display("test address done");
    whead({1'b0, 7'($urandom)});
    for (int i = 0; i < 6; i++)
    begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'hc0 : 8'($urandom);
      wb(d, 1'b0);
      exp_w = d[5:0];
      repeat (3) @(negedge ref_clk);
      check({2'h0, wiper}, {2'h0, exp_w});
    end
    i_mst.stop();
    // Instruction only, cut short by a repeated start
    whead(8'h7f);
    rd(adr(1'b1), 1'b0, exp_rd(2'h0, exp_w));
    $display("test write done");
    whead({1'b1, 7'($urandom)});
    wb(8'($urandom), 1'b0);
    i_mst.stop();
    check({7'h0, blown}, 8'h01);
    rd(adr(1'b1), 1'b0, exp_rd(2'h3, exp_w));
    check({6'h0, chk_hi, chk_lo}, 8'h03);
    whead(8'h80);
    wb({2'h0, ~exp_w}, 1'b0);
    i_mst.stop();
    repeat (3) @(negedge ref_clk);
    check({2'h0, wiper}, {2'h0, exp_w});
    $display("test program done");
    // Master acknowledges the first read byte, so the same byte comes again
    i_mst.start();
    wb(adr(1'b1), 1'b0);
    for (int k = 0; k < 2; k++)
    begin
      i_mst.xfer(8'hff, 1'(k), d, mack_seen);
      check(d, exp_rd(2'h3, exp_w));
    end
    i_mst.stop();
    $display("test repeat_read done");
    end_of_test();
  end
  // Hang guard
  initial
  begin
    #300000;
    n_fail++;
    end_of_test();
  end
endmodule : tb_owi_slave
`default_nettype wire

// *** src/owi_pkg.sv ***
// Purpose: Shared constants, types and state records of the wiper serial slave.
// Assumes: ref_clk at 100 MHz; SCL is the link clock.
// Notes: All states are one-hot; every figure is named once here.
package owi_pkg;

  // Fixed upper six address bits
  localparam logic [5:0] OWI_ADDR_HI = 6'h16;
  // Address byte field positions
  localparam int OWI_SEL_BIT = 1;
  localparam int OWI_RW_BIT = 0;
  // Instruction byte permanent-program bit
  localparam int OWI_PROG_BIT = 7;

  // Bit counter marks: last data bit and acknowledge slot
  localparam logic [3:0] OWI_BIT_LAST = 4'h7;
  localparam logic [3:0] OWI_BIT_ACK = 4'h8;

  // Reset values and the programmed fuse state
  localparam logic [5:0] OWI_MIDSCALE = 6'h20;
  localparam logic [1:0] OWI_FUSE_READY = 2'h0;
  localparam logic [1:0] OWI_FUSE_DONE = 2'h3;

  // Timing
  localparam int OWI_CLK_HZ = 100_000_000;
  localparam int OWI_PROG_TIME_MS = 400;
  localparam int OWI_PROG_CYCLES = OWI_PROG_TIME_MS * (OWI_CLK_HZ / 1000);
  localparam int OWI_CNT_W = 26;
  // Cycles after reset release before fuse levels are trusted
  localparam logic [1:0] OWI_BOOT_CYCLES = 2'h3;

  // Link protocol phase
  typedef enum logic [4:0] {
    OWI_PH_IDLE = 5'h01,
    OWI_PH_ADDR = 5'h02,
    OWI_PH_INSTR = 5'h04,
    OWI_PH_DATA = 5'h08,
    OWI_PH_READ = 5'h10
  } owi_ph_t;

  // Core control state
  typedef enum logic [3:0] {
    OWI_ST_BOOT = 4'h1,
    OWI_ST_RUN = 4'h2,
    OWI_ST_BURN = 4'h4,
    OWI_ST_CHECK = 4'h8
  } owi_st_t;

  // Link state sampled on SCL rising edges
  typedef struct packed {
    owi_ph_t ph;
    owi_ph_t nxt;
    logic [3:0] bitcnt;
    logic [6:0] sh;
    logic ack;
    logic [7:0] tx;
    logic [5:0] wr_code;
    logic wr_tgl;
    logic prog_tgl;
    logic start_seen;
    logic stop_seen;
    logic stat_s1;
    logic stat_s2;
    logic stat_seen;
  } owi_link_t;

  // SDA driver state, updated on SCL falling edges
  typedef struct packed {
    logic sda_out;
    logic sda_oe;
  } owi_drv_t;

  // Core state on ref_clk
  typedef struct packed {
    owi_st_t st;
    logic [OWI_CNT_W-1:0] cnt;
    logic [1:0] boot_cnt;
    logic wr_s1;
    logic wr_s2;
    logic wr_seen;
    logic pr_s1;
    logic pr_s2;
    logic pr_seen;
    logic [1:0] fs1;
    logic [1:0] fs2;
    logic [5:0] fc1;
    logic [5:0] fc2;
    logic [5:0] wiper;
    logic [1:0] echk;
    logic blow;
    logic [7:0] stat;
    logic stat_tgl;
  } owi_core_t;

endpackage : owi_pkg

// *** src/owi_slave.sv ***
// Purpose: Two-wire serial slave for a 64-step one-time-programmable wiper.
// Assumes: SCL clocks the link logic; fuse array reports its state on pins.
// Notes: Open-drain SDA as input, output and enable; no tri-state here.
`timescale 1ns/100ps
`default_nettype none

module owi_slave #(
  parameter int PROG_CYCLES = owi_pkg::OWI_PROG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_select_pin,
  input wire logic [1:0] fuse_state,
  input wire logic [5:0] fuse_code,
  output logic [5:0] wiper_resistor,
  output logic fuse_blow,
  output logic fuse_check_hi,
  output logic fuse_check_lo
);

  // Burn counter must hold the whole programming time
  initial
  begin
    if (PROG_CYCLES < 1 || PROG_CYCLES >= (2 ** owi_pkg::OWI_CNT_W))
    begin
      $error("PROG_CYCLES out of range");
    end
  end

  // Last burn count, sized to the counter
  localparam logic [owi_pkg::OWI_CNT_W-1:0] BURN_LAST = owi_pkg::OWI_CNT_W'(PROG_CYCLES - 1);

  // Start and stop event toggles, clocked by SDA itself
  logic start_tgl;
  logic stop_tgl;

  // Link records
  owi_pkg::owi_link_t lk;
  owi_pkg::owi_link_t next_lk;
  owi_pkg::owi_drv_t dv;
  owi_pkg::owi_drv_t next_dv;

  // Core records
  owi_pkg::owi_core_t cr;
  owi_pkg::owi_core_t next_cr;

  // Byte completed in this SCL rising edge
  logic [7:0] rx_byte;
  assign rx_byte = {lk.sh, sda_in};

  // Start: SDA falls while SCL is high; our own drive only moves with SCL low
  always_ff @(negedge sda_in or negedge resetn)
  begin
    if (!resetn)
    begin
      start_tgl <= 1'b0;
    end
    else if (scl_in)
    begin
      start_tgl <= ~start_tgl;
    end
  end

  // Stop: SDA rises while SCL is high
  always_ff @(posedge sda_in or negedge resetn)
  begin
    if (!resetn)
    begin
      stop_tgl <= 1'b0;
    end
    else if (scl_in)
    begin
      stop_tgl <= ~stop_tgl;
    end
  end

  // Link protocol on SCL rising edges, where SDA is stable
  always_comb
  begin
    next_lk = lk;
    // Status word handshake: toggle passes two flops, word is then stable
    next_lk.stat_s1 = cr.stat_tgl;
    next_lk.stat_s2 = lk.stat_s1;
    if (lk.stat_s2 != lk.stat_seen)
    begin
      next_lk.stat_seen = lk.stat_s2;
      next_lk.tx = cr.stat;
    end
    if (start_tgl != lk.start_seen)
    begin
      // Fresh start: this edge carries the first address bit
      next_lk.start_seen = start_tgl;
      next_lk.stop_seen = stop_tgl;
      next_lk.ph = owi_pkg::OWI_PH_ADDR;
      next_lk.sh = {6'h00, sda_in};
      next_lk.bitcnt = 4'h1;
      next_lk.ack = 1'b0;
    end
    else if (stop_tgl != lk.stop_seen)
    begin
      // Stop seen since last edge: drop everything
      next_lk.stop_seen = stop_tgl;
      next_lk.ph = owi_pkg::OWI_PH_IDLE;
      next_lk.ack = 1'b0;
    end
    else
    begin
      case (lk.ph)
        owi_pkg::OWI_PH_ADDR, owi_pkg::OWI_PH_INSTR, owi_pkg::OWI_PH_DATA:
        begin
          if (lk.bitcnt == owi_pkg::OWI_BIT_ACK)
          begin
            // Ninth pulse over: move on
            next_lk.bitcnt = 4'h0;
            next_lk.ack = 1'b0;
            next_lk.ph = lk.nxt;
          end
          else if (lk.bitcnt == owi_pkg::OWI_BIT_LAST)
          begin
            // Eighth bit in: the byte is complete
            next_lk.bitcnt = owi_pkg::OWI_BIT_ACK;
            if (lk.ph == owi_pkg::OWI_PH_ADDR)
            begin
              if (rx_byte[7:2] == owi_pkg::OWI_ADDR_HI &&
                  rx_byte[owi_pkg::OWI_SEL_BIT] == addr_select_pin)
              begin
                next_lk.ack = 1'b1;
                // Direction bit picks the path
                next_lk.nxt = rx_byte[owi_pkg::OWI_RW_BIT] ?
                  owi_pkg::OWI_PH_READ : owi_pkg::OWI_PH_INSTR;
              end
              else
              begin
                // Not ours: silent until the next start
                next_lk.ph = owi_pkg::OWI_PH_IDLE;
              end
            end
            else if (lk.ph == owi_pkg::OWI_PH_INSTR)
            begin
              next_lk.ack = 1'b1;
              next_lk.nxt = owi_pkg::OWI_PH_DATA;
              // Only the MSB counts; a write may end here with no data
              if (rx_byte[owi_pkg::OWI_PROG_BIT])
              begin
                next_lk.prog_tgl = ~lk.prog_tgl;
              end
            end
            else
            begin
              // Each data byte is one wiper update; upper bits dropped
              next_lk.ack = 1'b1;
              next_lk.nxt = owi_pkg::OWI_PH_DATA;
              next_lk.wr_code = rx_byte[5:0];
              next_lk.wr_tgl = ~lk.wr_tgl;
            end
          end
          else
          begin
            // Shift MSB first
            next_lk.sh = rx_byte[6:0];
            next_lk.bitcnt = lk.bitcnt + 4'h1;
          end
        end
        owi_pkg::OWI_PH_READ:
        begin
          if (lk.bitcnt == owi_pkg::OWI_BIT_ACK)
          begin
            // Master ack asks for another byte, no-ack ends the read
            next_lk.bitcnt = 4'h0;
            if (sda_in)
            begin
              next_lk.ph = owi_pkg::OWI_PH_IDLE;
            end
          end
          else
          begin
            next_lk.bitcnt = lk.bitcnt + 4'h1;
          end
        end
        owi_pkg::OWI_PH_IDLE:
        begin
          next_lk.ack = 1'b0;
        end
        default:
        begin
          next_lk.ph = owi_pkg::OWI_PH_IDLE;
          next_lk.ack = 1'b0;
        end
      endcase
    end
  end

  // Link register on SCL rising edges
  always_ff @(posedge scl_in or negedge resetn)
  begin
    if (!resetn)
    begin
      lk <= '{ph: owi_pkg::OWI_PH_IDLE, nxt: owi_pkg::OWI_PH_IDLE,
              tx: {owi_pkg::OWI_FUSE_READY, owi_pkg::OWI_MIDSCALE}, default: '0};
    end
    else
    begin
      lk <= next_lk;
    end
  end

  // SDA drive decided on SCL falling edges only
  always_comb
  begin
    next_dv.sda_out = 1'b0;
    next_dv.sda_oe = 1'b0;
    if (lk.ack)
    begin
      // Pull low through the ninth pulse
      next_dv.sda_oe = 1'b1;
    end
    else if (lk.ph == owi_pkg::OWI_PH_READ && lk.bitcnt < owi_pkg::OWI_BIT_ACK)
    begin
      // Open drain: a zero bit pulls low, a one releases
      next_dv.sda_oe = ~lk.tx[3'(owi_pkg::OWI_BIT_LAST - lk.bitcnt)];
    end
  end

  // Driver register; falling edge keeps SDA steady while SCL is high
  always_ff @(negedge scl_in or negedge resetn)
  begin
    if (!resetn)
    begin
      dv <= '0;
    end
    else
    begin
      dv <= next_dv;
    end
  end

  // Core: fuse boot, wiper updates, programming sequence
  always_comb
  begin
    next_cr = cr;
    // Event toggles and fuse pins through two flops each
    next_cr.wr_s1 = lk.wr_tgl;
    next_cr.wr_s2 = cr.wr_s1;
    next_cr.pr_s1 = lk.prog_tgl;
    next_cr.pr_s2 = cr.pr_s1;
    next_cr.fs1 = fuse_state;
    next_cr.fs2 = cr.fs1;
    next_cr.fc1 = fuse_code;
    next_cr.fc2 = cr.fc1;
    case (cr.st)
      owi_pkg::OWI_ST_BOOT:
      begin
        // Let the synchronisers settle before trusting the fuses
        next_cr.boot_cnt = cr.boot_cnt + 2'h1;
        next_cr.wr_seen = cr.wr_s2;
        next_cr.pr_seen = cr.pr_s2;
        if (cr.boot_cnt == owi_pkg::OWI_BOOT_CYCLES)
        begin
          next_cr.st = owi_pkg::OWI_ST_RUN;
          next_cr.echk = cr.fs2;
          // Blown part comes up at its frozen code, else midscale
          if (cr.fs2 == owi_pkg::OWI_FUSE_DONE)
          begin
            next_cr.wiper = cr.fc2;
          end
        end
      end
      owi_pkg::OWI_ST_RUN:
      begin
        if (cr.wr_s2 != cr.wr_seen)
        begin
          next_cr.wr_seen = cr.wr_s2;
          // Frozen after a successful burn
          if (cr.echk != owi_pkg::OWI_FUSE_DONE)
          begin
            next_cr.wiper = lk.wr_code;
          end
        end
        if (cr.pr_s2 != cr.pr_seen)
        begin
          next_cr.pr_seen = cr.pr_s2;
          if (cr.echk != owi_pkg::OWI_FUSE_DONE)
          begin
            // Burn the present wiper position
            next_cr.st = owi_pkg::OWI_ST_BURN;
            next_cr.cnt = '0;
            next_cr.blow = 1'b1;
          end
        end
      end
      owi_pkg::OWI_ST_BURN:
      begin
        // Data bytes arriving mid-burn are dropped, not queued
        next_cr.wr_seen = cr.wr_s2;
        next_cr.pr_seen = cr.pr_s2;
        next_cr.cnt = cr.cnt + 1'b1;
        if (cr.cnt == BURN_LAST)
        begin
          next_cr.blow = 1'b0;
          next_cr.st = owi_pkg::OWI_ST_CHECK;
        end
      end
      owi_pkg::OWI_ST_CHECK:
      begin
        // Fuse result becomes the validation bits
        next_cr.wr_seen = cr.wr_s2;
        next_cr.pr_seen = cr.pr_s2;
        next_cr.echk = cr.fs2;
        next_cr.st = owi_pkg::OWI_ST_RUN;
      end
      default:
      begin
        next_cr.st = owi_pkg::OWI_ST_BOOT;
        next_cr.blow = 1'b0;
      end
    endcase
    // Publish status to the link whenever it changes
    if ({next_cr.echk, next_cr.wiper} != cr.stat)
    begin
      next_cr.stat = {next_cr.echk, next_cr.wiper};
      next_cr.stat_tgl = ~cr.stat_tgl;
    end
  end

  // Core register
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cr <= '{st: owi_pkg::OWI_ST_BOOT, wiper: owi_pkg::OWI_MIDSCALE,
              echk: owi_pkg::OWI_FUSE_READY,
              stat: {owi_pkg::OWI_FUSE_READY, owi_pkg::OWI_MIDSCALE},
              default: '0};
    end
    else
    begin
      cr <= next_cr;
    end
  end

  // Outputs straight from flops
  assign sda_out = dv.sda_out;
  assign sda_oe = dv.sda_oe;
  assign wiper_resistor = cr.wiper;
  assign fuse_blow = cr.blow;
  assign fuse_check_hi = cr.echk[1];
  assign fuse_check_lo = cr.echk[0];

endmodule : owi_slave

`default_nettype wire
